// ===== rtl/stx_params.svh
// register offsets, field positions and constants of the skip/table/xor unit
`ifndef STX_PARAMS_SVH
`define STX_PARAMS_SVH
`define STX_ACC_OFS 11'h000
`define STX_TABLE_POINTER_LOW_OFS 11'h004
`define STX_TABLE_POINTER_HIGH_OFS 11'h008
`define STX_TABLE_HIGH_LATCH_OFS 11'h00c
`define STX_STAT_OFS 11'h010
`define STX_DM_BASE 11'h400
`define STX_DM_SEL_BIT 10
`define STX_ZF_BIT 0
`define STX_BUSY_BIT 1
`define STX_LAST_PAGE 8'hff
`define STX_BYTE_RST 8'h00
`define STX_PTR_INC 8'h01
`endif

// ===== rtl/stx_pkg.sv
// types shared by the skip/table/xor execution unit
package stx_pkg;
   typedef enum logic [3:0] {
      skip_if_zero_op,
      copy_skip_if_zero_op,
      bit_skip_if_zero_op,
      page_table_fetch_op,
      last_page_table_fetch_op,
      preinc_page_table_fetch_op,
      preinc_last_page_fetch_op,
      xor_to_accumulator_op,
      xor_to_memory_op
   } stx_op_t;

   typedef enum logic [1:0] {st_idle, st_exec, st_dummy} stx_fsm_t;

   typedef struct packed {
      logic valid;
      stx_op_t op;
      logic [7:0] addr;
      logic [2:0] bsel;
   } stx_instr_t;

   typedef struct packed {
      stx_fsm_t fsm;
      stx_op_t op;
      logic [7:0] addr;
      logic [2:0] bsel;
      logic [7:0] acc;
      logic [7:0] table_pointer_low;
      logic [7:0] table_pointer_high;
      logic [7:0] table_high_latch;
      logic zf;
      logic [15:0] pm_addr;
      logic skip;
      logic done;
      logic ack;
      logic [31:0] rdata;
   } stx_state_t;
endpackage

// ===== rtl/stx_exec.sv
// skip, table read and xor execution unit with avalon-mm register access
`timescale 1ns/1ps
`include "stx_params.svh"
// Overview of operation
// [RULE1] byte skip: rewrite byte, skip when zero
// [RULE2] taken skip adds dummy cycle, three total
// [RULE3] copy byte to accumulator, skip when zero
// [RULE4] skip when selected bit is zero
// [RULE5] page fetch uses both pointer bytes
// [RULE6] last page fetch uses low pointer only
// [RULE7] page fetch after low pointer increment
// [RULE8] last page fetch after low pointer increment
// [RULE9] xor into accumulator, zero flag only
// [RULE10] xor into memory, zero flag only
// [RULE11] low pointer wraps, table reads keep flags
module stx_exec (
   input wire logic i_sys_clk,
   input wire logic i_nrst,
   input wire stx_pkg::stx_instr_t i_instr,
   output logic o_instr_ready,
   output logic [15:0] o_pm_addr,
   input wire logic [15:0] i_pm_data,
   output logic o_skip,
   output logic o_done,
   output logic [7:0] o_acc,
   output logic o_zero_flag,
   input wire logic [10:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0] i_avs_byteenable,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest
);

   stx_pkg::stx_state_t st_r;
   stx_pkg::stx_state_t st_nxt;
   logic [7:0] dm_mem [0:255];

   logic [7:0] rd_byte;
   logic bit_val;
   logic [7:0] xor_val;
   logic bus_req;
   logic bus_dm;
   logic [7:0] bus_idx;
   logic accept;
   logic [7:0] table_pointer_low_inc;
   logic dm_we;
   logic [7:0] dm_wa;
   logic [7:0] dm_wd;
   logic [31:0] rd_mux;
   logic take_skip;

   assign rd_byte = dm_mem[st_r.addr];
   assign bit_val = rd_byte[st_r.bsel];
   assign xor_val = st_r.acc ^ rd_byte;
   assign bus_req = i_avs_read | i_avs_write;
   assign bus_dm = i_avs_address[`STX_DM_SEL_BIT];
   assign bus_idx = i_avs_address[9:2];
   // wraps modulo 256, high pointer never carries
   assign table_pointer_low_inc = st_r.table_pointer_low + `STX_PTR_INC; // [RULE11]

   // bus has priority so register reads never see a half-done instruction
   assign o_instr_ready = (st_r.fsm == stx_pkg::st_idle) && !bus_req;
   assign accept = i_instr.valid & o_instr_ready;
   assign o_avs_waitrequest = bus_req & !st_r.ack;
   assign o_avs_readdata = st_r.rdata;
   assign o_pm_addr = st_r.pm_addr;
   assign o_skip = st_r.skip;
   assign o_done = st_r.done;
   assign o_acc = st_r.acc;
   assign o_zero_flag = st_r.zf;

   always_comb begin
      rd_mux = '0;
      if (bus_dm) begin
         rd_mux[7:0] = dm_mem[bus_idx];
      end else begin
         case (i_avs_address)
            `STX_ACC_OFS: rd_mux[7:0] = st_r.acc;
            `STX_TABLE_POINTER_LOW_OFS: rd_mux[7:0] = st_r.table_pointer_low;
            `STX_TABLE_POINTER_HIGH_OFS: rd_mux[7:0] = st_r.table_pointer_high;
            `STX_TABLE_HIGH_LATCH_OFS: rd_mux[7:0] = st_r.table_high_latch;
            `STX_STAT_OFS: begin
               rd_mux[`STX_ZF_BIT] = st_r.zf;
               rd_mux[`STX_BUSY_BIT] = (st_r.fsm != stx_pkg::st_idle);
            end
            default: rd_mux = '0;
         endcase
      end
   end

   always_comb begin
      st_nxt = st_r;
      st_nxt.skip = 1'b0;
      st_nxt.done = 1'b0;
      st_nxt.ack = 1'b0;
      dm_we = 1'b0;
      dm_wa = st_r.addr;
      dm_wd = rd_byte;
      take_skip = 1'b0;

      // first bus cycle captures read data, second completes
      if (bus_req && !st_r.ack && st_r.fsm == stx_pkg::st_idle) begin
         st_nxt.ack = 1'b1;
         st_nxt.rdata = rd_mux;
      end
      if (bus_req && st_r.ack && i_avs_write && i_avs_byteenable[0]) begin
         if (bus_dm) begin
            dm_we = 1'b1;
            dm_wa = bus_idx;
            dm_wd = i_avs_writedata[7:0];
         end else begin
            case (i_avs_address)
               `STX_ACC_OFS: st_nxt.acc = i_avs_writedata[7:0];
               `STX_TABLE_POINTER_LOW_OFS: st_nxt.table_pointer_low = i_avs_writedata[7:0];
               `STX_TABLE_POINTER_HIGH_OFS: st_nxt.table_pointer_high = i_avs_writedata[7:0];
               `STX_STAT_OFS: st_nxt.zf = i_avs_writedata[`STX_ZF_BIT];
               default: ;
            endcase
         end
      end

      case (st_r.fsm)
         stx_pkg::st_idle: begin
            if (accept) begin
               st_nxt.fsm = stx_pkg::st_exec;
               st_nxt.op = i_instr.op;
               st_nxt.addr = i_instr.addr;
               st_nxt.bsel = i_instr.bsel;
               case (i_instr.op)
                  stx_pkg::page_table_fetch_op: begin
                     st_nxt.pm_addr = {st_r.table_pointer_high,
                        st_r.table_pointer_low}; // [RULE5]
                  end
                  stx_pkg::last_page_table_fetch_op: begin
                     st_nxt.pm_addr = {`STX_LAST_PAGE, st_r.table_pointer_low}; // [RULE6]
                  end
                  stx_pkg::preinc_page_table_fetch_op: begin
                     st_nxt.table_pointer_low = table_pointer_low_inc; // [RULE7]
                     st_nxt.pm_addr = {st_r.table_pointer_high, table_pointer_low_inc}; // [RULE7]
                  end
                  stx_pkg::preinc_last_page_fetch_op: begin
                     st_nxt.table_pointer_low = table_pointer_low_inc; // [RULE8]
                     st_nxt.pm_addr = {`STX_LAST_PAGE, table_pointer_low_inc}; // [RULE8]
                  end
                  default: ;
               endcase
            end
         end
         stx_pkg::st_exec: begin
            case (st_r.op)
               stx_pkg::skip_if_zero_op: begin
                  dm_we = 1'b1; // [RULE1]
                  take_skip = (rd_byte == `STX_BYTE_RST); // [RULE1]
               end
               stx_pkg::copy_skip_if_zero_op: begin
                  st_nxt.acc = rd_byte; // [RULE3]
                  take_skip = (rd_byte == `STX_BYTE_RST); // [RULE3]
               end
               stx_pkg::bit_skip_if_zero_op: begin
                  take_skip = !bit_val; // [RULE4]
               end
               stx_pkg::page_table_fetch_op,
               stx_pkg::last_page_table_fetch_op,
               stx_pkg::preinc_page_table_fetch_op,
               stx_pkg::preinc_last_page_fetch_op: begin
                  // flags left alone on purpose
                  dm_we = 1'b1; // [RULE5] [RULE6] [RULE11]
                  dm_wd = i_pm_data[7:0];
                  st_nxt.table_high_latch = i_pm_data[15:8]; // [RULE5] [RULE6]
               end
               stx_pkg::xor_to_accumulator_op: begin
                  st_nxt.acc = xor_val; // [RULE9]
                  st_nxt.zf = (xor_val == `STX_BYTE_RST); // [RULE9]
               end
               stx_pkg::xor_to_memory_op: begin
                  dm_we = 1'b1; // [RULE10]
                  dm_wd = xor_val;
                  st_nxt.zf = (xor_val == `STX_BYTE_RST); // [RULE10]
               end
               default: ;
            endcase
            if (take_skip) begin
               st_nxt.fsm = stx_pkg::st_dummy; // [RULE2]
               st_nxt.skip = 1'b1;
            end else begin
               st_nxt.fsm = stx_pkg::st_idle;
               st_nxt.done = 1'b1;
            end
         end
         stx_pkg::st_dummy: begin
            // dummy slot stands in for the discarded fetch
            st_nxt.fsm = stx_pkg::st_idle; // [RULE2]
            st_nxt.done = 1'b1;
         end
         default: st_nxt.fsm = stx_pkg::st_idle;
      endcase
   end

   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // data memory has no reset; software must initialise it
   always_ff @(posedge i_sys_clk) begin
      if (dm_we) begin
         dm_mem[dm_wa] <= dm_wd;
      end
   end

   byte_skip_a: assert property ( // [RULE1]
      @(posedge i_sys_clk) disable iff (!i_nrst)
      (st_r.fsm == stx_pkg::st_exec && st_r.op == stx_pkg::skip_if_zero_op)
      |=> (o_skip == ($past(rd_byte) == 8'h00)) && (dm_mem[$past(st_r.addr)] == $past(rd_byte)))
      else $error("byte skip decision or writeback wrong");

   skip_length_a: assert property ( // [RULE2]
      @(posedge i_sys_clk) disable iff (!i_nrst)
      accept ##1 (st_r.fsm == stx_pkg::st_exec && take_skip)
      |=> o_skip && !o_done ##1 o_done && !o_skip && o_instr_ready == !bus_req)
      else $error("taken skip does not last three cycles");

   copy_skip_a: assert property ( // [RULE3]
      @(posedge i_sys_clk) disable iff (!i_nrst)
      (st_r.fsm == stx_pkg::st_exec && st_r.op == stx_pkg::copy_skip_if_zero_op)
      |=> o_acc == $past(rd_byte) && o_skip == (o_acc == 8'h00) && $stable(o_zero_flag))
      else $error("copy skip wrong");

   bit_skip_a: assert property ( // [RULE4]
      @(posedge i_sys_clk) disable iff (!i_nrst)
      (st_r.fsm == stx_pkg::st_exec && st_r.op == stx_pkg::bit_skip_if_zero_op)
      |=> o_skip == !$past(bit_val) && $stable(o_zero_flag) && $stable(o_acc))
      else $error("bit skip wrong");

   page_fetch_a: assert property ( // [RULE5]
      @(posedge i_sys_clk) disable iff (!i_nrst)
      (accept && i_instr.op == stx_pkg::page_table_fetch_op)
      ##1 1'b1
      |=> st_r.table_high_latch == $past(i_pm_data[15:8])
      && dm_mem[$past(st_r.addr)] == $past(i_pm_data[7:0])
      && $past(o_pm_addr) == $past({st_r.table_pointer_high, st_r.table_pointer_low}))
      else $error("page table fetch wrong");

   last_page_a: assert property ( // [RULE6]
      @(posedge i_sys_clk) disable iff (!i_nrst)
      (accept && i_instr.op == stx_pkg::last_page_table_fetch_op)
      |=> o_pm_addr == {8'hff, $past(st_r.table_pointer_low)})
      else $error("last page address wrong");

   // word split checked one cycle after the address is presented
   last_page_data_a: assert property ( // [RULE6]
      @(posedge i_sys_clk) disable iff (!i_nrst)
      (accept && i_instr.op == stx_pkg::last_page_table_fetch_op)
      ##1 1'b1
      |=> st_r.table_high_latch == $past(i_pm_data[15:8])
      && dm_mem[$past(st_r.addr)] == $past(i_pm_data[7:0]))
      else $error("last page word split wrong");

   // high address byte must follow the page kind, not the low pointer carry
   preinc_fetch_a: assert property ( // [RULE7] [RULE8]
      @(posedge i_sys_clk) disable iff (!i_nrst)
      (accept && (i_instr.op == stx_pkg::preinc_page_table_fetch_op
      || i_instr.op == stx_pkg::preinc_last_page_fetch_op)) ##1 1'b1
      |=> st_r.table_high_latch == $past(i_pm_data[15:8])
      && dm_mem[$past(st_r.addr)] == $past(i_pm_data[7:0])
      && $past(o_pm_addr[15:8]) == (($past(st_r.op) == stx_pkg::preinc_last_page_fetch_op)
      ? 8'hff : $past(st_r.table_pointer_high)))
      else $error("pre-increment fetch wrong");

   preinc_ptr_a: assert property ( // [RULE7] [RULE8] [RULE11]
      @(posedge i_sys_clk) disable iff (!i_nrst)
      (accept && (i_instr.op == stx_pkg::preinc_page_table_fetch_op
      || i_instr.op == stx_pkg::preinc_last_page_fetch_op))
      |=> st_r.table_pointer_low == 8'($past(st_r.table_pointer_low) + 8'h01)
      && $stable(st_r.table_pointer_high)
      && o_pm_addr[7:0] == st_r.table_pointer_low)
      else $error("pre-increment pointer wrong");

   xor_acc_a: assert property ( // [RULE9]
      @(posedge i_sys_clk) disable iff (!i_nrst)
      (st_r.fsm == stx_pkg::st_exec && st_r.op == stx_pkg::xor_to_accumulator_op)
      |=> o_acc == $past(xor_val) && o_zero_flag == (o_acc == 8'h00) && o_done)
      else $error("xor to accumulator wrong");

   xor_mem_a: assert property ( // [RULE10]
      @(posedge i_sys_clk) disable iff (!i_nrst)
      (st_r.fsm == stx_pkg::st_exec && st_r.op == stx_pkg::xor_to_memory_op)
      |=> dm_mem[$past(st_r.addr)] == $past(xor_val) && $stable(o_acc)
      && o_zero_flag == ($past(xor_val) == 8'h00))
      else $error("xor to memory wrong");

   table_flags_a: assert property ( // [RULE11]
      @(posedge i_sys_clk) disable iff (!i_nrst)
      (st_r.fsm == stx_pkg::st_exec && !bus_req
      && (st_r.op == stx_pkg::page_table_fetch_op
      || st_r.op == stx_pkg::last_page_table_fetch_op
      || st_r.op == stx_pkg::preinc_page_table_fetch_op
      || st_r.op == stx_pkg::preinc_last_page_fetch_op))
      |=> $stable(o_zero_flag) && !o_skip && o_done)
      else $error("table read touched flags or skipped");

endmodule

// ===== testbench/skip_table_xor_exec_tb_top.sv
// self-checking bench for the skip, table read and xor unit
`timescale 1ns/1ps
`include "stx_params.svh"
module skip_table_xor_exec_tb_top;
   logic i_sys_clk = 1'b0;
   logic i_nrst = 1'b0;
   stx_pkg::stx_instr_t i_instr = '0;
   logic [15:0] i_pm_data;
   logic [10:0] i_avs_address = 11'h000;
   logic i_avs_read = 1'b0;
   logic i_avs_write = 1'b0;
   logic [31:0] i_avs_writedata = 32'h00000000;
   logic [3:0] i_avs_byteenable = 4'h0;
   logic o_instr_ready, o_skip, o_done, o_zero_flag, o_avs_waitrequest;
   logic [15:0] o_pm_addr;
   logic [7:0] o_acc;
   logic [31:0] o_avs_readdata;
   int mismatches = 0;
   int comparisons = 0;
   int cyc = 0;
   logic [31:0] rng = 32'h0000003b;
   always #2 i_sys_clk = ~i_sys_clk;
   // program memory answers in the same cycle, word depends on both page and offset
   function automatic logic [15:0] pm_word(input logic [15:0] a);
      return {a[7:0] ^ a[15:8] ^ 8'h3c, a[15:8] + a[7:0]};
   endfunction
   assign i_pm_data = pm_word(o_pm_addr);
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction
   function automatic logic [10:0] dm(input logic [7:0] m);
      return `STX_DM_BASE | {1'b0, m, 2'b00};
   endfunction
   stx_exec dut (
      .i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_instr(i_instr),
      .o_instr_ready(o_instr_ready), .o_pm_addr(o_pm_addr), .i_pm_data(i_pm_data),
      .o_skip(o_skip), .o_done(o_done), .o_acc(o_acc), .o_zero_flag(o_zero_flag),
      .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
      .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable),
      .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest)
   );
   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // hang guard, generous for about two thousand cycles of traffic
   always @(posedge i_sys_clk) begin
      cyc++;
      if (cyc == 20000) begin
         mismatches++;
         wrap_up();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   // request held until waitrequest is sampled low at a rising edge, released there
   task automatic bus(input logic wr, input logic [10:0] a, input logic [31:0] d,
                      input logic [3:0] be, output logic [31:0] q);
      @(posedge i_sys_clk);
      i_avs_address <= a;
      i_avs_writedata <= d;
      i_avs_byteenable <= be;
      i_avs_write <= wr;
      i_avs_read <= !wr;
      do @(posedge i_sys_clk); while (o_avs_waitrequest !== 1'b0);
      q = o_avs_readdata;
      i_avs_write <= 1'b0;
      i_avs_read <= 1'b0;
   endtask
   task automatic wr(input logic [10:0] a, input logic [7:0] d);
      logic [31:0] q;
      bus(1'b1, a, {24'h000000, d}, 4'h1, q);
   endtask
   task automatic rd_chk(input logic [10:0] a, input logic [31:0] exp, input string what);
      logic [31:0] q;
      bus(1'b0, a, 32'h00000000, 4'hf, q);
      chk(q, exp, what);
   endtask
   task automatic run(input stx_pkg::stx_op_t op, input logic [7:0] a, input logic [2:0] b,
                      output logic sk, output int n, output logic [15:0] pa);
      @(posedge i_sys_clk);
      i_instr <= '{1'b1, op, a, b};
      do @(posedge i_sys_clk); while (o_instr_ready !== 1'b1);
      i_instr.valid <= 1'b0;
      sk = 1'b0;
      n = 0;
      pa = 16'h0000;
      do begin
         @(negedge i_sys_clk);
         n++;
         if (n == 1) pa = o_pm_addr;
         if (o_skip === 1'b1) sk = 1'b1;
      end while (o_done !== 1'b1 && n < 8);
   endtask
   function automatic void predict(input stx_pkg::stx_op_t op, input logic [7:0] h,
      input logic [2:0] bb, inout logic [7:0] acc, inout logic [7:0] mem,
      inout logic [7:0] p, inout logic [7:0] tl, inout logic zf,
      output logic sk, output logic [15:0] pa);
      logic [15:0] w;
      sk = 1'b0;
      pa = 16'h0000;
      if (op == stx_pkg::preinc_page_table_fetch_op || op == stx_pkg::preinc_last_page_fetch_op)
         p = p + `STX_PTR_INC;
      case (op)
         stx_pkg::skip_if_zero_op: sk = (mem == 8'h00);
         stx_pkg::copy_skip_if_zero_op: begin
            acc = mem;
            sk = (mem == 8'h00);
         end
         stx_pkg::bit_skip_if_zero_op: sk = !mem[bb];
         stx_pkg::xor_to_accumulator_op: begin
            acc = acc ^ mem;
            zf = (acc == 8'h00);
         end
         stx_pkg::xor_to_memory_op: begin
            mem = acc ^ mem;
            zf = (mem == 8'h00);
         end
         default: begin
            if (op == stx_pkg::page_table_fetch_op || op == stx_pkg::preinc_page_table_fetch_op)
               pa = {h, p};
            else
               pa = {`STX_LAST_PAGE, p};
            w = pm_word(pa);
            mem = w[7:0];
            tl = w[15:8];
         end
      endcase
   endfunction
   initial begin
      stx_pkg::stx_op_t op;
      logic [7:0] m, v, ac, p, h, etl;
      logic [2:0] bb;
      logic z, esk, sk;
      logic [15:0] epa, pa;
      logic [31:0] q;
      int k, n;
      etl = 8'h00;
      repeat (16) @(posedge i_sys_clk);
      i_nrst <= 1'b1;
      chk({o_skip, o_done, o_zero_flag, o_acc}, 32'h0, "outputs after reset");
      for (int r = 0; r < 5; r++) rd_chk(11'(4 * r), 32'h0, "register after reset");
      $display("reset values checked");
      for (int i = 0; i < 40; i++) begin
         rng = xs(rng);
         k = (i < 9) ? i : int'(rng[3:0]) % 9;
         op = stx_pkg::stx_op_t'(k);
         m = rng[11:4];
         bb = rng[14:12];
         v = (i % 3 == 0) ? 8'h00 : rng[23:16];
         rng = xs(rng);
         // first pass forces pointer wrap on pre-increments and zero xor results
         ac = (i % 5 == 0 || i == 7 || i == 8) ? v : rng[7:0];
         p = (i % 4 == 0 || i == 5 || i == 6) ? 8'hff : rng[15:8];
         h = rng[23:16];
         z = rng[24];
         wr(dm(m), v);
         wr(`STX_ACC_OFS, ac);
         wr(`STX_TABLE_POINTER_LOW_OFS, p);
         wr(`STX_TABLE_POINTER_HIGH_OFS, h);
         wr(`STX_STAT_OFS, {7'h00, z});
         run(op, m, bb, sk, n, pa);
         predict(op, h, bb, ac, v, p, etl, z, esk, epa);
         chk(n, esk ? 32'd3 : 32'd2, "cycles to done");
         chk({31'h0, o_instr_ready}, 32'h1, "ready in done cycle");
         chk({31'h0, sk}, {31'h0, esk}, "skip taken");
         if (k >= 3 && k <= 6) chk(pa, epa, "table address");
         rd_chk(`STX_ACC_OFS, ac, "accumulator");
         chk(o_acc, ac, "acc port");
         rd_chk(dm(m), v, "data byte");
         rd_chk(`STX_TABLE_POINTER_LOW_OFS, p, "pointer low");
         rd_chk(`STX_TABLE_POINTER_HIGH_OFS, h, "pointer high");
         rd_chk(`STX_TABLE_HIGH_LATCH_OFS, etl, "high latch");
         rd_chk(`STX_STAT_OFS, {31'h0, z}, "status");
         chk(o_zero_flag, z, "zero flag port");
         $display("test %0d op %0d finished", i, k);
      end
      // refused accesses leave state alone; upper write lanes are dropped, low byte still written
      bus(1'b1, `STX_TABLE_HIGH_LATCH_OFS, ~{24'h0, etl}, 4'h1, q);
      rd_chk(`STX_TABLE_HIGH_LATCH_OFS, etl, "read-only latch");
      bus(1'b1, `STX_ACC_OFS, 32'h0000005a, 4'h0, q);
      rd_chk(`STX_ACC_OFS, ac, "lane disabled write");
      bus(1'b1, 11'h020, 32'h000000ff, 4'h1, q);
      rd_chk(11'h020, 32'h0, "unmapped");
      bus(1'b1, `STX_ACC_OFS, 32'hffffffa5, 4'hf, q);
      rd_chk(`STX_ACC_OFS, 32'h000000a5, "upper lanes");
      $display("bus corner test finished");
      wrap_up();
   end
endmodule
